/* File: hw/scde_defs.vh */
`ifndef SCDE_DEFS_VH
`define SCDE_DEFS_VH
// register byte offsets
`define SCDE_OFS_INSTR 8'h00
`define SCDE_OFS_STAT 8'h04
`define SCDE_OFS_ACC 8'h08
`define SCDE_OFS_PC 8'h0C
`define SCDE_OFS_HLATCH 8'h10
`define SCDE_OFS_STACK 8'h14
`define SCDE_OFS_WDOG 8'h18
`define SCDE_OFS_FADDR 8'h1C
`define SCDE_OFS_FDATA 8'h20
// status register bit positions
`define SCDE_ST_BUSY 0
`define SCDE_ST_NULL 1
`define SCDE_ST_EXPIRY 2
`define SCDE_ST_SLEEP 3
`define SCDE_ST_SKIP 4
`define SCDE_ST_ILLEGAL 5
// reset values
`define SCDE_RST_PC 15'h0000
`define SCDE_RST_ACC 8'h00
`define SCDE_RST_HLATCH 7'h00
`define SCDE_RST_WDOG 8'h00
// instruction word fields
`define SCDE_CLASS_HI 13
`define SCDE_CLASS_LO 8
`define SCDE_DEST_BIT 7
`define SCDE_FILE_HI 6
`define SCDE_CALL_HI 13
`define SCDE_CALL_LO 11
// instruction encodings
`define SCDE_CLS_ERASE 6'h01
`define SCDE_CLS_INVERT 6'h09
`define SCDE_CLS_DEC 6'h03
`define SCDE_CLS_DECSKIP 6'h0B
`define SCDE_CALL_TOP 3'h4
`define SCDE_OPC_KICK 14'h0064
`define SCDE_OPC_ACALL 14'h000F
// timing: one instruction cycle and the core clock
`define SCDE_TCY_NS 40
`define SCDE_CLK_NS 10
`define SCDE_TCY_CLKS (`SCDE_TCY_NS / `SCDE_CLK_NS)
`endif

/* File: hw/scde_file_mem.v */
`timescale 1ns/1ps
// file register space, one write port, registered read
module scde_file_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    // clock
    input wire clk,
    // write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // read port
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    // storage array, no reset
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // write, then registered read
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // scde_file_mem

/* File: hw/scde_stack.v */
`timescale 1ns/1ps
// return stack, push only, top held in a register
module scde_stack #(
    parameter PW = 15,
    parameter DEPTH_LOG2 = 4
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // push port
    input wire push,
    input wire [PW-1:0] push_data,
    // state
    output reg [PW-1:0] top,
    output reg [DEPTH_LOG2:0] depth
);
    reg [PW-1:0] mem [0:(1<<DEPTH_LOG2)-1]; // entries
    reg [DEPTH_LOG2-1:0] ptr_reg; // next free slot, wraps on overflow

    // storage write
    always @(posedge clk) begin
        if (push) begin
            mem[ptr_reg] <= push_data;
        end
    end

    // pointer, depth and top copy
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg <= {DEPTH_LOG2{1'b0}};
            depth <= {(DEPTH_LOG2+1){1'b0}};
            top <= {PW{1'b0}};
        end else if (push) begin
            ptr_reg <= ptr_reg + 1'b1;
            top <= push_data;
            // depth saturates at full
            if (depth != (1 << DEPTH_LOG2)) begin
                depth <= depth + 1'b1;
            end
        end
    end
endmodule // scde_stack

/* File: hw/scde_core.v */
`timescale 1ns/1ps
`include "scde_defs.vh"
module scde_core #(
    parameter CYC_DIV = `SCDE_TCY_CLKS,
    parameter STACK_LOG2 = 4
) (
    // clock and reset
    input wire CLK,
    input wire ARST_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output wire PSLVERR,
    output reg [31:0] PRDATA
);
    // execution states
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_EXEC = 2'd2;
    localparam ST_SECOND = 2'd3;

    // decoded operation kinds
    localparam K_NOP = 3'd0;
    localparam K_CALL = 3'd1;
    localparam K_ACALL = 3'd2;
    localparam K_FERASE = 3'd3;
    localparam K_AERASE = 3'd4;
    localparam K_KICK = 3'd5;
    localparam K_FILE = 3'd6;

    // decode an instruction word into an operation kind
    function [2:0] op_kind;
        input [13:0] w;
        begin
            if (w[`SCDE_CALL_HI:`SCDE_CALL_LO] == `SCDE_CALL_TOP) begin
                op_kind = K_CALL;
            end else if (w == `SCDE_OPC_ACALL) begin
                op_kind = K_ACALL;
            end else if (w == `SCDE_OPC_KICK) begin
                op_kind = K_KICK;
            end else if (w[`SCDE_CLASS_HI:`SCDE_CLASS_LO] == `SCDE_CLS_ERASE) begin
                op_kind = w[`SCDE_DEST_BIT] ? K_FERASE : K_AERASE;
            end else if (w[`SCDE_CLASS_HI:`SCDE_CLASS_LO] == `SCDE_CLS_INVERT
                || w[`SCDE_CLASS_HI:`SCDE_CLASS_LO] == `SCDE_CLS_DEC
                || w[`SCDE_CLASS_HI:`SCDE_CLASS_LO] == `SCDE_CLS_DECSKIP) begin
                op_kind = K_FILE;
            end else begin
                op_kind = K_NOP;
            end
        end
    endfunction

    // true when a byte is all zero
    function is_null;
        input [7:0] v;
        begin
            is_null = (v == 8'h00);
        end
    endfunction

    // architectural state
    reg [14:0] pc_reg; // program counter
    reg [7:0] acc_reg; // accumulator
    reg [6:0] hlatch_reg; // program counter high latch
    reg null_reg; // null-result flag
    reg expiry_reg; // expiry status bit, 1 = no timeout
    reg sleep_reg; // sleep entry flag
    reg skip_reg; // last instruction skipped
    reg illegal_reg; // last instruction not in this group
    reg [13:0] instr_reg; // instruction being executed
    reg [1:0] state_reg; // execution state
    reg [6:0] faddr_reg; // software file address
    // watchdog counter and prescaler
    reg [7:0] wdog_reg;
    reg [7:0] wpre_reg;
    // instruction cycle divider
    reg [7:0] div_reg;
    wire tick; // one-cycle pulse per instruction cycle
    // apb access phase second cycle
    reg ack_reg;

    // instruction fields
    wire [5:0] cls = instr_reg[`SCDE_CLASS_HI:`SCDE_CLASS_LO];
    wire dest = instr_reg[`SCDE_DEST_BIT];
    wire [6:0] fsel = instr_reg[`SCDE_FILE_HI:0];
    wire [2:0] kind = op_kind(instr_reg);
    wire busy = (state_reg != ST_IDLE);

    // file memory ports
    wire [7:0] fval; // registered read data
    reg fwr_en;
    reg [6:0] fwr_addr;
    reg [7:0] fwr_data;
    wire [6:0] frd_addr = busy ? fsel : faddr_reg;

    // stack ports
    reg push;
    wire [14:0] stack_top;
    wire [STACK_LOG2:0] stack_depth;

    // alu result for file operations
    reg [7:0] result;
    wire res_null = is_null(result);
    wire is_skip_op = (cls == `SCDE_CLS_DECSKIP);

    // apb decode
    wire acc_phase = PSEL & PENABLE;
    wire wr_fire = acc_phase & ack_reg & PWRITE;
    reg map_hit; // address in map
    reg busy_refuse; // write refused while executing
    wire refused = ~map_hit | (PWRITE & busy_refuse);
    wire wr_ok = wr_fire & ~refused;

    assign tick = (div_reg == CYC_DIV - 1);
    assign PREADY = acc_phase & ack_reg;
    assign PSLVERR = PREADY & refused;

    // file and stack memories
    scde_file_mem #(.AW(7), .DW(8)) u_fmem (
        .clk(CLK),
        .wr_en(fwr_en),
        .wr_addr(fwr_addr),
        .wr_data(fwr_data),
        .rd_addr(frd_addr),
        .rd_data(fval)
    );

    scde_stack #(.PW(15), .DEPTH_LOG2(STACK_LOG2)) u_stack (
        .clk(CLK),
        .arst_n(ARST_N),
        .push(push),
        .push_data(pc_reg + 15'h0001),
        .top(stack_top),
        .depth(stack_depth)
    );

    // address decode and refusal classes
    always @* begin
        map_hit = 1'b1;
        busy_refuse = 1'b0;
        case (PADDR)
            `SCDE_OFS_INSTR, `SCDE_OFS_ACC, `SCDE_OFS_PC,
            `SCDE_OFS_HLATCH, `SCDE_OFS_FDATA: busy_refuse = busy;
            `SCDE_OFS_STAT, `SCDE_OFS_STACK, `SCDE_OFS_WDOG,
            `SCDE_OFS_FADDR: busy_refuse = 1'b0;
            default: map_hit = 1'b0;
        endcase
    end

    // result of invert or decrement
    always @* begin
        if (cls == `SCDE_CLS_INVERT) begin
            result = ~fval;
        end else begin
            result = fval - 8'h01;
        end
    end

    // memory write and stack push selection
    always @* begin
        fwr_en = 1'b0;
        fwr_addr = faddr_reg;
        fwr_data = PWDATA[7:0];
        push = 1'b0;
        if (state_reg == ST_EXEC && tick) begin
            fwr_addr = fsel;
            case (kind)
                K_CALL, K_ACALL: push = 1'b1;
                K_FERASE: begin
                    fwr_en = 1'b1;
                    fwr_data = 8'h00;
                end
                K_FILE: begin
                    fwr_en = dest;
                    fwr_data = result;
                end
                default: fwr_en = 1'b0;
            endcase
        end else if (wr_ok && PADDR == `SCDE_OFS_FDATA) begin
            fwr_en = 1'b1;
        end
    end

    // instruction cycle divider
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_reg <= 8'h00;
        end else if (tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // apb access phase pacing: one wait cycle for the read data
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= acc_phase & ~ack_reg;
        end
    end

    // read data captured in the first access cycle
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h00000000;
        end else if (acc_phase && !ack_reg && !PWRITE) begin
            case (PADDR)
                `SCDE_OFS_INSTR: PRDATA <= {18'h00000, instr_reg};
                `SCDE_OFS_STAT: PRDATA <= {26'h0000000, illegal_reg, skip_reg, sleep_reg,
                                           expiry_reg, null_reg, busy};
                `SCDE_OFS_ACC: PRDATA <= {24'h000000, acc_reg};
                `SCDE_OFS_PC: PRDATA <= {17'h00000, pc_reg};
                `SCDE_OFS_HLATCH: PRDATA <= {25'h0000000, hlatch_reg};
                `SCDE_OFS_STACK: PRDATA <= {{(16-STACK_LOG2-1){1'b0}}, stack_depth, 1'b0, stack_top};
                `SCDE_OFS_WDOG: PRDATA <= {16'h0000, wpre_reg, wdog_reg};
                `SCDE_OFS_FADDR: PRDATA <= {25'h0000000, faddr_reg};
                `SCDE_OFS_FDATA: PRDATA <= {24'h000000, fval};
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

    // execution sequencer
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= ST_IDLE;
            instr_reg <= 14'h0000;
        end else begin
            case (state_reg)
                // software write issues an instruction
                ST_IDLE: begin
                    if (wr_ok && PADDR == `SCDE_OFS_INSTR) begin
                        instr_reg <= PWDATA[13:0];
                        state_reg <= ST_WAIT;
                    end
                end
                // one clock for the file read to settle
                ST_WAIT: state_reg <= ST_EXEC;
                // first instruction cycle
                ST_EXEC: begin
                    if (tick) begin
                        if (kind == K_CALL || kind == K_ACALL) begin
                            state_reg <= ST_SECOND;
                        end else if (kind == K_FILE && is_skip_op && res_null) begin
                            state_reg <= ST_SECOND;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                // second instruction cycle, a dead slot
                ST_SECOND: begin
                    if (tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // program counter and high latch
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_reg <= `SCDE_RST_PC;
            hlatch_reg <= `SCDE_RST_HLATCH;
        end else if (state_reg == ST_EXEC && tick) begin
            case (kind)
                K_CALL: pc_reg <= {hlatch_reg[6:3], instr_reg[10:0]};
                K_ACALL: pc_reg <= {hlatch_reg, acc_reg};
                default: pc_reg <= pc_reg + 15'h0001;
            endcase
        end else if (state_reg == ST_SECOND && tick && kind == K_FILE) begin
            // skipped instruction is stepped over as a no-operation
            pc_reg <= pc_reg + 15'h0001;
        end else if (wr_ok) begin
            if (PADDR == `SCDE_OFS_PC) begin
                pc_reg <= PWDATA[14:0];
            end
            if (PADDR == `SCDE_OFS_HLATCH) begin
                hlatch_reg <= PWDATA[6:0];
            end
        end
    end

    // accumulator and null flag
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_reg <= `SCDE_RST_ACC;
            null_reg <= 1'b0;
        end else if (state_reg == ST_EXEC && tick) begin
            case (kind)
                K_FERASE: null_reg <= 1'b1;
                K_AERASE: begin
                    acc_reg <= 8'h00;
                    null_reg <= 1'b1;
                end
                K_FILE: begin
                    if (!dest) begin
                        acc_reg <= result;
                    end
                    if (!is_skip_op) begin
                        null_reg <= res_null;
                    end
                end
                default: null_reg <= null_reg;
            endcase
        end else if (wr_ok && PADDR == `SCDE_OFS_ACC) begin
            acc_reg <= PWDATA[7:0];
        end
    end

    // skip and illegal markers for the last instruction
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            skip_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else if (state_reg == ST_EXEC && tick) begin
            skip_reg <= (kind == K_FILE) && is_skip_op && res_null;
            illegal_reg <= (kind == K_NOP);
        end
    end

    // software file address
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            faddr_reg <= 7'h00;
        end else if (wr_ok && PADDR == `SCDE_OFS_FADDR) begin
            faddr_reg <= PWDATA[6:0];
        end
    end

    // watchdog counter, prescaler and its status bits
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdog_reg <= `SCDE_RST_WDOG;
            wpre_reg <= `SCDE_RST_WDOG;
            expiry_reg <= 1'b1;
            sleep_reg <= 1'b1;
        end else if (state_reg == ST_EXEC && tick && kind == K_KICK) begin
            wdog_reg <= 8'h00;
            wpre_reg <= 8'h00;
            expiry_reg <= 1'b1;
            sleep_reg <= 1'b1;
        end else begin
            // counts instruction cycles, timeout drops the expiry bit
            if (tick) begin
                wpre_reg <= wpre_reg + 8'h01;
                if (wpre_reg == 8'hFF) begin
                    wdog_reg <= wdog_reg + 8'h01;
                    if (wdog_reg == 8'hFF) begin
                        expiry_reg <= 1'b0;
                    end
                end
            end
            // software marks sleep entry by writing zero
            if (wr_ok && PADDR == `SCDE_OFS_STAT && !PWDATA[`SCDE_ST_SLEEP]) begin
                sleep_reg <= 1'b0;
            end
        end
    end
endmodule // scde_core

/* File: testbench/scde_apb_host.sv */
`timescale 1ns/1ps
// apb master standing in for software
module scde_apb_host (
    // clock
    input wire logic clk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // answer
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer; ok stays low when no answer comes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && !ok; n++) begin
            // answer and data are taken at the rising edge that sees pready high
            @(posedge clk);
            if (pready === 1'b1) begin
                q = prdata;
                e = pslverr;
                ok = 1'b1;
            end
        end
        // released lines stop showing the old request
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // scde_apb_host

/* File: testbench/scde_core_sva.sv */
`timescale 1ns/1ps
`include "scde_defs.vh"
// apb-side checker for the execute block
module scde_core_sva (
    // clock and reset
    input wire CLK,
    input wire ARST_N,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire [31:0] PRDATA
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // accepted writes and finished reads
    wire wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    wire rd_ok = PSEL && PENABLE && PREADY && !PWRITE;
    // software shadows and the state seen at the last issue
    reg [14:0] pc_reg;
    reg [14:0] ipc_reg;
    reg [7:0] acc_reg;
    reg [7:0] iacc_reg;
    reg [6:0] hl_reg;
    reg [6:0] ihl_reg;
    reg [13:0] ins_reg;
    reg pcw_reg;
    reg accw_reg;
    reg hlw_reg;
    reg known_reg;
    reg idle_reg;
    reg kick_reg;
    // track writes, issues and idle status reads
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ins_reg <= 14'h0000;
            pcw_reg <= 1'b0;
            accw_reg <= 1'b0;
            hlw_reg <= 1'b0;
            known_reg <= 1'b0;
            idle_reg <= 1'b0;
            kick_reg <= 1'b0;
        end else begin
            if (wr_ok && PADDR == `SCDE_OFS_PC) begin
                pc_reg <= PWDATA[14:0];
                pcw_reg <= 1'b1;
            end
            if (wr_ok && PADDR == `SCDE_OFS_ACC) begin
                acc_reg <= PWDATA[7:0];
                accw_reg <= 1'b1;
            end
            if (wr_ok && PADDR == `SCDE_OFS_HLATCH) begin
                hl_reg <= PWDATA[6:0];
                hlw_reg <= 1'b1;
            end
            // issue: snapshot what the instruction starts from
            if (wr_ok && PADDR == `SCDE_OFS_INSTR) begin
                ins_reg <= PWDATA[13:0];
                ipc_reg <= pc_reg;
                iacc_reg <= acc_reg;
                ihl_reg <= hl_reg;
                known_reg <= pcw_reg && accw_reg && hlw_reg;
                pcw_reg <= 1'b0;
                accw_reg <= 1'b0;
                idle_reg <= 1'b0;
                kick_reg <= PWDATA[13:0] == `SCDE_OPC_KICK;
            end
            if (wr_ok && PADDR == `SCDE_OFS_STAT) begin
                kick_reg <= 1'b0;
            end
            if (rd_ok && PADDR == `SCDE_OFS_STAT && !PRDATA[0]) begin
                idle_reg <= 1'b1;
            end
        end
    end

    a_ready_timing: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
        else $error("pready not in second access cycle");
    a_ready_scope: assert property (PREADY |-> PSEL && PENABLE)
        else $error("pready outside access phase");
    a_rdata_held: assert property ($changed(PRDATA) |-> $past(PSEL && PENABLE && !PWRITE && !PREADY))
        else $error("read data changed outside a read");
    a_call_push:
        assert property (rd_ok && PADDR == `SCDE_OFS_STACK && idle_reg && known_reg
            && (ins_reg[13:11] == 3'h4 || ins_reg == `SCDE_OPC_ACALL) |-> PRDATA[14:0] == ipc_reg + 15'h1)
        else $error("pushed return address wrong");
    a_call_low:
        assert property (rd_ok && PADDR == `SCDE_OFS_PC && idle_reg && known_reg && !pcw_reg
            && ins_reg[13:11] == 3'h4 |-> PRDATA[10:0] == ins_reg[10:0])
        else $error("call target low bits wrong");
    a_call_high:
        assert property (rd_ok && PADDR == `SCDE_OFS_PC && idle_reg && known_reg && !pcw_reg
            && ins_reg[13:11] == 3'h4 |-> PRDATA[14:11] == ihl_reg[6:3])
        else $error("call target high bits wrong");
    a_acc_call_pc:
        assert property (rd_ok && PADDR == `SCDE_OFS_PC && idle_reg && known_reg && !pcw_reg
            && ins_reg == `SCDE_OPC_ACALL |-> PRDATA[14:0] == {ihl_reg, iacc_reg})
        else $error("accumulator call target wrong");
    a_erase_null:
        assert property (rd_ok && PADDR == `SCDE_OFS_STAT && !PRDATA[0]
            && ins_reg[13:8] == `SCDE_CLS_ERASE |-> PRDATA[1])
        else $error("null flag not set after erase");
    a_kick_flags:
        assert property (rd_ok && PADDR == `SCDE_OFS_STAT && !PRDATA[0] && kick_reg |-> PRDATA[3:2] == 2'b11)
        else $error("kick left status bits low");
endmodule // scde_core_sva

bind scde_core scde_core_sva u_sva (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA));

/* File: testbench/scde_tb_top.sv */
`timescale 1ns/1ps
`include "scde_defs.vh"
// self-checking bench for the execute block
module subroutine_clear_decrement_exec_tb_top;
    // clock, reset and bus wires
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // verdict counters
    int fail_count = 0;
    int checks = 0;
    logic [31:0] q; // last read data
    logic e; // last error answer
    int nbusy; // busy polls of the last instruction

    always #5 clk = ~clk;

    scde_core #(.CYC_DIV(4), .STACK_LOG2(4)) u_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PSLVERR(pslverr), .PRDATA(prdata));
    scde_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

    // verdict and end of run
    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer; a missing answer ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        u_host.xfer(w, a, d, q, e, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // poll status until the core is idle
    task automatic settle();
        nbusy = 0;
        for (int i = 0; i < 30; i++) begin
            bus(1'b0, `SCDE_OFS_STAT, 32'h0);
            if (q[0] !== 1'b1) break;
            nbusy++;
        end
        if (q[0] !== 1'b0) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic run(input logic [13:0] ins);
        bus(1'b1, `SCDE_OFS_INSTR, {18'h0, ins});
        settle();
    endtask
    // file operation with destination, result, skip and null checks
    task automatic fop(input logic [5:0] cl, input logic d, input logic [6:0] f, input logic [7:0] v);
        logic [7:0] r;
        logic z0;
        r = (cl == `SCDE_CLS_INVERT) ? ~v : v - 8'h01;
        bus(1'b0, `SCDE_OFS_STAT, 32'h0);
        z0 = q[1];
        bus(1'b1, `SCDE_OFS_FADDR, {25'h0, f});
        bus(1'b1, `SCDE_OFS_FDATA, {24'h0, v});
        bus(1'b1, `SCDE_OFS_ACC, 32'h3C);
        bus(1'b1, `SCDE_OFS_PC, 32'h0200);
        run({cl, d, f});
        // transfers and ticks share a four-clock period, so the busy poll count is fixed
        chk(nbusy, (cl == `SCDE_CLS_DECSKIP && r == 8'h00) ? 2 : 1);
        bus(1'b0, `SCDE_OFS_ACC, 32'h0);
        chk(q, d ? 32'h3C : {24'h0, r});
        bus(1'b0, `SCDE_OFS_FDATA, 32'h0);
        chk(q, {24'h0, d ? r : v});
        bus(1'b0, `SCDE_OFS_PC, 32'h0);
        chk(q, (cl == `SCDE_CLS_DECSKIP && r == 8'h00) ? 32'h0202 : 32'h0201);
        bus(1'b0, `SCDE_OFS_STAT, 32'h0);
        chk({31'h0, q[1]}, {31'h0, (cl == `SCDE_CLS_DECSKIP) ? z0 : r == 8'h00});
        chk({31'h0, q[4]}, {31'h0, cl == `SCDE_CLS_DECSKIP && r == 8'h00});
    endtask
    // both calls, a refused write while busy
    task automatic t_calls();
        bus(1'b1, `SCDE_OFS_HLATCH, 32'h5A);
        bus(1'b1, `SCDE_OFS_ACC, 32'hC3);
        bus(1'b1, `SCDE_OFS_PC, 32'h1234);
        run({3'h4, 11'h2AB});
        chk(nbusy, 32'h2);
        bus(1'b0, `SCDE_OFS_PC, 32'h0);
        chk(q, {17'h0, 4'hB, 11'h2AB});
        bus(1'b0, `SCDE_OFS_STACK, 32'h0);
        chk(q, 32'h0001_1235);
        bus(1'b1, `SCDE_OFS_ACC, 32'hC3);
        bus(1'b1, `SCDE_OFS_PC, 32'h0100);
        bus(1'b1, `SCDE_OFS_INSTR, {18'h0, `SCDE_OPC_ACALL});
        bus(1'b1, `SCDE_OFS_ACC, 32'h77);
        chk({31'h0, e}, 32'h1);
        settle();
        // the refused write used up the first poll slot
        chk(nbusy, 32'h1);
        bus(1'b0, `SCDE_OFS_PC, 32'h0);
        chk(q, 32'h5AC3);
        bus(1'b0, `SCDE_OFS_STACK, 32'h0);
        chk(q, 32'h0002_0101);
    endtask
    // erases, then the watchdog kick after the counter has moved
    task automatic t_clear();
        run({6'h01, 1'b1, 7'h7F});
        bus(1'b1, `SCDE_OFS_FADDR, 32'h7F);
        bus(1'b0, `SCDE_OFS_FDATA, 32'h0);
        chk(q, 32'h0);
        fop(`SCDE_CLS_INVERT, 1'b0, 7'h7F, 8'h00);
        run({6'h01, 1'b0, 7'h00});
        bus(1'b0, `SCDE_OFS_ACC, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `SCDE_OFS_STAT, 32'h0);
        repeat (1100) @(posedge clk);
        bus(1'b0, `SCDE_OFS_WDOG, 32'h0);
        chk({31'h0, q[7:0] != 8'h00}, 32'h1);
        run(`SCDE_OPC_KICK);
        bus(1'b0, `SCDE_OFS_WDOG, 32'h0);
        chk({31'h0, q[15:0] < 16'h0800}, 32'h1);
        bus(1'b0, `SCDE_OFS_STAT, 32'h0);
        chk({30'h0, q[3:2]}, 32'h3);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        fop(`SCDE_CLS_DECSKIP, 1'b0, 7'h00, 8'h01);
        fop(`SCDE_CLS_DECSKIP, 1'b1, 7'h7F, 8'h80);
        fop(`SCDE_CLS_DECSKIP, 1'b1, 7'h40, 8'h01);
        fop(`SCDE_CLS_DEC, 1'b0, 7'h11, 8'h01);
        fop(`SCDE_CLS_DEC, 1'b1, 7'h7F, 8'h00);
        fop(`SCDE_CLS_INVERT, 1'b1, 7'h22, 8'hFF);
        fop(`SCDE_CLS_INVERT, 1'b0, 7'h00, 8'h5A);
        t_calls();
        t_clear();
        // a word outside the group marks the last instruction as foreign
        run(14'h3FFF);
        bus(1'b0, `SCDE_OFS_STAT, 32'h0);
        chk({31'h0, q[5]}, 32'h1);
        // unmapped place answers with an error and zero
        bus(1'b0, 8'h24, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        tally_and_finish();
    end
endmodule // subroutine_clear_decrement_exec_tb_top
